// ### logic/acq_regs.vh
`ifndef ACQ_REGS_VH
`define ACQ_REGS_VH
// Register offsets
`define OFS_BOARD_CONTROL   7'h00
`define OFS_RATE_A          7'h04
`define OFS_RATE_B          7'h08
`define OFS_ASSIGN          7'h0C
`define OFS_DIVISORS        7'h10
`define OFS_REF_FREQ        7'h18
`define OFS_RATE_SYNC       7'h1C
`define OFS_BUF_CTRL        7'h20
`define OFS_OPTIONS         7'h24
`define OFS_FILL_COUNT      7'h28
`define OFS_CAL_VALUES      7'h2C
`define OFS_DATA_PORT       7'h30
// Reset values
`define RST_BCR_STD         32'h0000383C
`define RST_BCR_LOWPWR      32'h00003838
`define RST_RATE            32'h00400032
`define RST_ASSIGN          32'h00000000
`define RST_DIVISORS        32'h00000505
`define RST_RATE_SYNC       32'h00002000
`define RST_BUF_CTRL        32'h0003FFFE
`define OPTIONS_VALUE       32'h00000000
// Board control fields
`define BCR_WMASK           32'h001F8FFF
`define BCR_SYNC            6
`define BCR_CAL             7
`define BCR_PASS            12
`define BCR_READY           13
`define BCR_THRESH          14
`define BCR_OFFBIN          4
`define BCR_INITIATOR       5
`define BCR_CLR_ON_SYNC     17
`define BCR_EXT_RATE_A      18
`define BCR_LOW_FILTER      19
// Buffer control fields
`define BUF_WMASK           32'h000FFFFF
`define BUF_DISABLE         18
`define BUF_CLEAR           19
`define BUF_FULL            24
// Assignment fields
`define ASN_DISABLE0        4
// Data path
`define NUM_CHAN            12
`define GROUP_SIZE          6
`define WORD_BITS           24
`define GAIN_UNITY          16'h4000
`define GAIN_FRAC           14
`define CAL_TARGET          24'h7EB851
`define FIFO_AW             8
`define FIFO_DEPTH          9'h100
// Input routing codes
`define SEL_ZERO            2'h1
`define SEL_FULL            2'h2
// Timing
`define CLK_PERIOD_NS       4
`define SETTLE_NS           2000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### logic/word_deserializer.v
`timescale 1ns/1ps
module word_deserializer (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        frame_i,
  input  wire        bit_i,
  input  wire        sdata_i,
  output reg  [23:0] word_o,
  output reg         valid_o
);
  reg [4:0]  cnt_reg;
  reg [23:0] shift_reg;
  wire [23:0] shift_next = {shift_reg[22:0], sdata_i};

  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (reset_i) begin
      cnt_reg   <= 5'h00;
      shift_reg <= 24'h000000;
      word_o    <= 24'h000000;
    end else if (bit_i) begin
      shift_reg <= shift_next;
      if (cnt_reg == 5'h17 && !frame_i) begin
        word_o  <= shift_next;
        valid_o <= 1'b1;
        cnt_reg <= 5'h00;
      end else begin
        cnt_reg <= frame_i ? 5'h01 : cnt_reg + 5'h01;
      end
    end else if (frame_i) begin
      cnt_reg <= 5'h00;
    end
  end
endmodule

// ### logic/sample_corrector.v
`timescale 1ns/1ps
module sample_corrector (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [23:0] raw_i,
  input  wire [4:0]  tag_i,
  input  wire        valid_i,
  input  wire [23:0] offset_i,
  input  wire [15:0] gain_i,
  output reg  [23:0] data_o,
  output reg  [4:0]  tag_o,
  output reg         valid_o
);
  wire signed [24:0] diff   = $signed({raw_i[23], raw_i})
                            - $signed({offset_i[23], offset_i});
  wire signed [41:0] prod   = diff * $signed({1'b0, gain_i});
  wire        [27:0] scaled = prod[41:14];
  wire               same   = &scaled[27:23] | ~|scaled[27:23];

  always @(posedge clk_i) begin
    if (reset_i) begin
      data_o  <= 24'h000000;
      tag_o   <= 5'h00;
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
      tag_o   <= tag_i;
      if (same)
        data_o <= scaled[23:0];
      else if (scaled[27])
        data_o <= 24'h800000;
      else
        data_o <= 24'h7FFFFF;
    end
  end
endmodule

// ### logic/acq_controller.v
// Summary of operation
// - Twelve channels form two groups; only active groups feed the buffer.
// - Each 24-bit serial converter word is deserialized to parallel first.
// - Tag word with 5-bit channel, then correct, then write to buffer.
// - Software may start self-calibration at any moment.
// - Calibration first routes zero reference and records each channel.
// - Then derives gain per channel from reference; stores both in memory.
// - Reference taken as 99.00 percent of full scale, never saturating.
// - Two rate generators, each divided by a programmed integer divisor.
// - Either generator can be assigned to either group independently.
// - External clock output is rate generator or sample clock.
// - Initiator originates clock; target receives and passes it on.
// - Registers are 32-bit words at byte offsets; 0x14, 0x34-0x7C reserved.
// - Board control resets to 0x383C, or 0x3838 in low power.
// - Buffer full sets board control bit 14, reading 0x783C or 0x7838.
// - Buffer control resets to 0x0003FFFE, reads 0x0103FFFE when full.
// - Rate A/B reset 0x00400032; assignment zero; divisors 0x0505.
// - Rate sync control resets to 0x00002000.
// - A read-only register reports values held in the buffer.
// - Data port read pops oldest word with channel tag; DMA capable.
// - Self-test and calibration route zero or full-scale reference.
// - An output selects one of two image filter cutoffs.
// - Writing bit 7 starts calibration; hardware clears it when done.
// - Pass bit 12 set at reset and start; cleared on failed calibration.
// - Ready bit 13 low while parameters change, high once stable.
`timescale 1ns/1ps
`include "acq_regs.vh"
module acq_controller (
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire        LOW_POWER_I,
  input  wire [6:0]  LB_ADDR_I,
  input  wire        LB_WR_I,
  input  wire        LB_RD_I,
  input  wire [31:0] LB_WDATA_I,
  output reg  [31:0] LB_RDATA_O,
  output reg         LB_ACK_O,
  output reg         DMA_REQ_O,
  input  wire        ADC_FRAME_I,
  input  wire        ADC_BIT_I,
  input  wire        ADC_SDATA_I,
  output reg  [1:0]  ADC_SAMPLE_CLK_O,
  output reg         ADC_SYNC_O,
  input  wire        EXT_CLK_I,
  output reg         EXT_CLK_O,
  output reg  [1:0]  INPUT_SEL_O,
  output reg  [1:0]  RANGE_SEL_O,
  output reg         FILTER_LOW_O
);
  localparam C_IDLE  = 3'h0;
  localparam C_WAIT0 = 3'h1;
  localparam C_ZERO  = 3'h2;
  localparam C_WAIT1 = 3'h3;
  localparam C_FULL  = 3'h4;
  localparam C_DIV   = 3'h5;

  function hit;
    input [6:0] addr;
    input [6:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  reg [31:0] bcr_reg;
  reg [31:0] rate_reg [0:1];
  reg [31:0] assign_reg;
  reg [31:0] div_reg;
  reg [31:0] sync_reg;
  reg [31:0] buf_reg;
  reg [7:0]  live_assign_reg;
  reg [15:0] live_div_reg;
  reg        pending_reg;
  reg [9:0]  settle_reg;
  reg        ready_reg;
  reg        pass_reg;
  reg        fail_reg;
  reg [3:0]  cal_view_reg;

  wire wr_bcr  = LB_WR_I & hit(LB_ADDR_I, `OFS_BOARD_CONTROL);
  wire wr_rate = LB_WR_I & (hit(LB_ADDR_I, `OFS_RATE_A)
                          | hit(LB_ADDR_I, `OFS_RATE_B));
  wire wr_grp  = LB_WR_I & (hit(LB_ADDR_I, `OFS_ASSIGN)
                          | hit(LB_ADDR_I, `OFS_DIVISORS));
  wire rd_pop  = LB_RD_I & hit(LB_ADDR_I, `OFS_DATA_PORT);
  wire initiator = bcr_reg[`BCR_INITIATOR];

  // Converter word path
  wire [23:0] raw_word;
  wire        raw_valid;
  reg  [4:0]  chan_reg;
  word_deserializer deser (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .frame_i (ADC_FRAME_I),
    .bit_i   (ADC_BIT_I),
    .sdata_i (ADC_SDATA_I),
    .word_o  (raw_word),
    .valid_o (raw_valid)
  );

  always @(posedge CLK_I) begin
    if (RESET_I || ADC_FRAME_I)
      chan_reg <= 5'h00;
    else if (raw_valid)
      chan_reg <= chan_reg + 5'h01;
  end

  reg  [23:0] offset_mem [0:`NUM_CHAN-1];
  reg  [15:0] gain_mem   [0:`NUM_CHAN-1];
  reg  [24:0] meas_mem   [0:`NUM_CHAN-1];
  wire        chan_ok = (chan_reg < `NUM_CHAN);
  wire [3:0]  chan_idx = chan_ok ? chan_reg[3:0] : 4'h0;
  wire [23:0] corr_data;
  wire [4:0]  corr_tag;
  wire        corr_valid;
  sample_corrector corr (
    .clk_i    (CLK_I),
    .reset_i  (RESET_I),
    .raw_i    (raw_word),
    .tag_i    (chan_reg),
    .valid_i  (raw_valid & chan_ok),
    .offset_i (offset_mem[chan_idx]),
    .gain_i   (gain_mem[chan_idx]),
    .data_o   (corr_data),
    .tag_o    (corr_tag),
    .valid_o  (corr_valid)
  );

  // Calibration sequencer
  reg [2:0]  cal_state_reg;
  reg [3:0]  div_ch_reg;
  reg [5:0]  div_bit_reg;
  reg [37:0] quo_reg;
  reg [25:0] rem_reg;
  wire [24:0] divisor = meas_mem[div_ch_reg];
  wire [25:0] rem_shift = {rem_reg[24:0], quo_reg[37]};
  wire [25:0] rem_sub = rem_shift - {1'b0, divisor};
  wire        cal_busy = (cal_state_reg != C_IDLE);
  wire        cal_done = (cal_state_reg == C_DIV) && (div_bit_reg == 6'h00)
                       && (div_ch_reg == `NUM_CHAN - 1);
  wire        last_ch = raw_valid && (chan_reg == `NUM_CHAN - 1);
  wire        div_bad = divisor[24] || (divisor == 25'h0000000);
  integer i;

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      cal_state_reg <= C_IDLE;
      div_ch_reg    <= 4'h0;
      div_bit_reg   <= 6'h00;
      quo_reg       <= 38'h0;
      rem_reg       <= 26'h0;
      fail_reg      <= 1'b0;
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin
        offset_mem[i] <= 24'h000000;
        gain_mem[i]   <= `GAIN_UNITY;
        meas_mem[i]   <= 25'h0000000;
      end
    end else begin
      case (cal_state_reg)
        C_IDLE: begin
          if (bcr_reg[`BCR_CAL]) begin
            cal_state_reg <= C_WAIT0;
            fail_reg      <= 1'b0;
          end
        end
        C_WAIT0: begin
          if (ADC_FRAME_I)
            cal_state_reg <= C_ZERO;
        end
        C_ZERO: begin
          if (raw_valid && chan_ok)
            offset_mem[chan_idx] <= raw_word;
          if (last_ch)
            cal_state_reg <= C_WAIT1;
        end
        C_WAIT1: begin
          if (ADC_FRAME_I)
            cal_state_reg <= C_FULL;
        end
        C_FULL: begin
          if (raw_valid && chan_ok)
            meas_mem[chan_idx] <= {raw_word[23], raw_word}
                               - {offset_mem[chan_idx][23],
                                  offset_mem[chan_idx]};
          if (last_ch) begin
            cal_state_reg <= C_DIV;
            div_ch_reg    <= 4'h0;
            div_bit_reg   <= 6'h26;
            quo_reg       <= {`CAL_TARGET, 14'h0000};
            rem_reg       <= 26'h0;
          end
        end
        C_DIV: begin
          if (div_bit_reg != 6'h00) begin
            div_bit_reg <= div_bit_reg - 6'h01;
            if (!rem_sub[25]) begin
              rem_reg <= rem_sub;
              quo_reg <= {quo_reg[36:0], 1'b1};
            end else begin
              rem_reg <= rem_shift;
              quo_reg <= {quo_reg[36:0], 1'b0};
            end
          end else begin
            if (div_bad || quo_reg[37:16] != 22'h0) begin
              fail_reg             <= 1'b1;
              gain_mem[div_ch_reg] <= `GAIN_UNITY;
            end else begin
              gain_mem[div_ch_reg] <= quo_reg[15:0];
            end
            if (cal_done) begin
              cal_state_reg <= C_IDLE;
            end else begin
              div_ch_reg  <= div_ch_reg + 4'h1;
              div_bit_reg <= 6'h26;
              quo_reg     <= {`CAL_TARGET, 14'h0000};
              rem_reg     <= 26'h0;
            end
          end
        end
        default: cal_state_reg <= C_IDLE;
      endcase
    end
  end

  // Rate generators and group sample clocks
  reg         ext_prev_reg;
  wire [31:0] rst_assign = `RST_ASSIGN;
  wire [31:0] rst_div    = `RST_DIVISORS;
  wire [31:0] settle_cyc = `SETTLE_CYC;
  wire        ext_rise = EXT_CLK_I & ~ext_prev_reg;
  wire [1:0]  rate_tick;
  wire [1:0]  samp_tick;
  reg  [1:0]  rate_tog_reg;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : rate_gen
      reg  [15:0] cnt_reg;
      wire [15:0] lim = rate_reg[g][15:0];
      assign rate_tick[g] = (cnt_reg + 16'h0001 >= lim);
      always @(posedge CLK_I) begin
        if (RESET_I) begin
          cnt_reg         <= 16'h0000;
          rate_tog_reg[g] <= 1'b0;
        end else if (rate_tick[g]) begin
          cnt_reg         <= 16'h0000;
          rate_tog_reg[g] <= ~rate_tog_reg[g];
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
    for (g = 0; g < 2; g = g + 1) begin : group_clk
      reg  [7:0] cnt_reg;
      wire [7:0] lim = live_div_reg[8*g+7:8*g];
      wire       src = initiator ? rate_tick[live_assign_reg[g]]
                                 : ext_rise;
      assign samp_tick[g] = src && (cnt_reg + 8'h01 >= lim);
      always @(posedge CLK_I) begin
        if (RESET_I) begin
          cnt_reg             <= 8'h00;
          ADC_SAMPLE_CLK_O[g] <= 1'b0;
        end else if (samp_tick[g]) begin
          cnt_reg             <= 8'h00;
          ADC_SAMPLE_CLK_O[g] <= ~ADC_SAMPLE_CLK_O[g];
        end else if (src) begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  endgenerate

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      ext_prev_reg    <= 1'b0;
      EXT_CLK_O       <= 1'b0;
      live_assign_reg <= rst_assign[7:0];
      live_div_reg    <= rst_div[15:0];
      pending_reg     <= 1'b0;
      settle_reg      <= 10'h000;
      ready_reg       <= 1'b1;
    end else begin
      ext_prev_reg <= EXT_CLK_I;
      if (!initiator)
        EXT_CLK_O <= EXT_CLK_I;
      else if (bcr_reg[`BCR_EXT_RATE_A])
        EXT_CLK_O <= rate_tog_reg[0];
      else
        EXT_CLK_O <= ADC_SAMPLE_CLK_O[0];
      if (wr_grp || wr_rate) begin
        pending_reg <= 1'b1;
      end else if (pending_reg && (|samp_tick || !initiator)) begin
        pending_reg     <= 1'b0;
        live_assign_reg <= assign_reg[7:0];
        live_div_reg    <= div_reg[15:0];
        settle_reg      <= settle_cyc[9:0];
      end else if (settle_reg != 10'h000) begin
        settle_reg <= settle_reg - 10'h001;
      end
      ready_reg <= !(wr_grp || wr_rate || pending_reg
                    || settle_reg > 10'h001);
    end
  end

  // Input buffer
  reg  [28:0] fifo_mem [0:(1<<`FIFO_AW)-1];
  reg  [7:0]  wr_ptr_reg;
  reg  [7:0]  rd_ptr_reg;
  reg  [8:0]  count_reg;
  wire        full = (count_reg == `FIFO_DEPTH);
  wire        empty = (count_reg == 9'h000);
  wire        grp_active = !live_assign_reg[`ASN_DISABLE0
                           + (corr_tag >= `GROUP_SIZE)];
  wire        push = corr_valid && grp_active && !cal_busy && !full
                   && !buf_reg[`BUF_DISABLE];
  wire        pop = rd_pop && !empty;
  wire        clr = buf_reg[`BUF_CLEAR] ||
                    (bcr_reg[`BCR_SYNC] && bcr_reg[`BCR_CLR_ON_SYNC]);
  wire        thresh = full || ({23'h0, count_reg} > buf_reg[17:0]);

  always @(posedge CLK_I) begin
    if (RESET_I || clr) begin
      wr_ptr_reg <= 8'h00;
      rd_ptr_reg <= 8'h00;
      count_reg  <= 9'h000;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= {corr_tag, corr_data};
        wr_ptr_reg <= wr_ptr_reg + 8'h01;
      end
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 8'h01;
      if (push && !pop)
        count_reg <= count_reg + 9'h001;
      else if (pop && !push)
        count_reg <= count_reg - 9'h001;
    end
  end

  // Register writes
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      bcr_reg <= LOW_POWER_I ? `RST_BCR_LOWPWR : `RST_BCR_STD;
      rate_reg[0] <= `RST_RATE;
      rate_reg[1] <= `RST_RATE;
      assign_reg  <= `RST_ASSIGN;
      div_reg     <= `RST_DIVISORS;
      sync_reg    <= `RST_RATE_SYNC;
      buf_reg     <= `RST_BUF_CTRL;
      pass_reg    <= 1'b1;
    end else begin
      if (wr_bcr)
        bcr_reg <= LB_WDATA_I & `BCR_WMASK;
      else
        bcr_reg[`BCR_SYNC] <= 1'b0;
      bcr_reg[`BCR_CAL] <= (wr_bcr & LB_WDATA_I[`BCR_CAL])
                         | (bcr_reg[`BCR_CAL] & ~cal_done);
      if (cal_state_reg == C_IDLE && bcr_reg[`BCR_CAL])
        pass_reg <= 1'b1;
      else if (cal_done)
        pass_reg <= ~(fail_reg | div_bad | (quo_reg[37:16] != 22'h0));
      if (LB_WR_I && hit(LB_ADDR_I, `OFS_RATE_A))
        rate_reg[0] <= LB_WDATA_I;
      if (LB_WR_I && hit(LB_ADDR_I, `OFS_RATE_B))
        rate_reg[1] <= LB_WDATA_I;
      if (LB_WR_I && hit(LB_ADDR_I, `OFS_ASSIGN))
        assign_reg <= LB_WDATA_I;
      if (LB_WR_I && hit(LB_ADDR_I, `OFS_DIVISORS))
        div_reg <= LB_WDATA_I;
      if (LB_WR_I && hit(LB_ADDR_I, `OFS_RATE_SYNC))
        sync_reg <= LB_WDATA_I;
      if (LB_WR_I && hit(LB_ADDR_I, `OFS_BUF_CTRL))
        buf_reg <= LB_WDATA_I & `BUF_WMASK;
      else
        buf_reg[`BUF_CLEAR] <= 1'b0;
    end
  end

  // Register reads
  reg [31:0] rd_mux;
  wire [28:0] head = fifo_mem[rd_ptr_reg];
  always @* begin
    rd_mux = 32'h00000000;
    case (LB_ADDR_I)
      `OFS_BOARD_CONTROL:
        rd_mux = {bcr_reg[31:15], thresh, ready_reg, pass_reg,
                  bcr_reg[11:0]};
      `OFS_RATE_A:     rd_mux = rate_reg[0];
      `OFS_RATE_B:     rd_mux = rate_reg[1];
      `OFS_ASSIGN:     rd_mux = assign_reg;
      `OFS_DIVISORS:   rd_mux = div_reg;
      `OFS_RATE_SYNC:  rd_mux = sync_reg;
      `OFS_BUF_CTRL:   rd_mux = {7'h00, full, buf_reg[23:0]};
      `OFS_OPTIONS:    rd_mux = `OPTIONS_VALUE;
      `OFS_FILL_COUNT: rd_mux = {23'h000000, count_reg};
      `OFS_CAL_VALUES:
        rd_mux = {gain_mem[cal_view_reg][15:8],
                  offset_mem[cal_view_reg]};
      `OFS_DATA_PORT:
        if (!empty)
          rd_mux = {3'h0, head[28:24],
                    head[23] ^ bcr_reg[`BCR_OFFBIN], head[22:0]};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      LB_RDATA_O   <= 32'h00000000;
      LB_ACK_O     <= 1'b0;
      DMA_REQ_O    <= 1'b0;
      ADC_SYNC_O   <= 1'b0;
      INPUT_SEL_O  <= 2'h0;
      RANGE_SEL_O  <= 2'h0;
      FILTER_LOW_O <= 1'b0;
      cal_view_reg <= 4'h0;
    end else begin
      LB_ACK_O   <= LB_RD_I | LB_WR_I;
      if (LB_RD_I)
        LB_RDATA_O <= rd_mux;
      if (LB_RD_I && hit(LB_ADDR_I, `OFS_CAL_VALUES))
        cal_view_reg <= (cal_view_reg == `NUM_CHAN - 1) ? 4'h0
                      : cal_view_reg + 4'h1;
      DMA_REQ_O  <= (count_reg > {8'h00, pop});
      ADC_SYNC_O <= bcr_reg[`BCR_SYNC];
      if (cal_state_reg == C_WAIT0 || cal_state_reg == C_ZERO)
        INPUT_SEL_O <= `SEL_ZERO;
      else if (cal_state_reg == C_WAIT1 || cal_state_reg == C_FULL)
        INPUT_SEL_O <= `SEL_FULL;
      else
        INPUT_SEL_O <= bcr_reg[1:0];
      RANGE_SEL_O  <= bcr_reg[3:2];
      FILTER_LOW_O <= bcr_reg[`BCR_LOW_FILTER];
    end
  end
endmodule

// ### testbench/acq_monitor.sv
`timescale 1ns/1ps
module acq_monitor (
  input wire logic        CLK_I, RESET_I, LOW_POWER_I, LB_WR_I, LB_RD_I,
  input wire logic [6:0]  LB_ADDR_I,
  input wire logic [31:0] LB_WDATA_I, LB_RDATA_O,
  input wire logic        LB_ACK_O, DMA_REQ_O, ADC_FRAME_I, ADC_BIT_I,
  input wire logic        ADC_SDATA_I, ADC_SYNC_O, EXT_CLK_I, EXT_CLK_O,
  input wire logic [1:0]  ADC_SAMPLE_CLK_O, INPUT_SEL_O, RANGE_SEL_O,
  input wire logic        FILTER_LOW_O
);
  logic init_reg;
  logic filt_reg;
  // Shadow of the clock role and filter bits
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      init_reg <= 1'b1;
      filt_reg <= 1'b0;
    end else if (LB_WR_I && LB_ADDR_I == 7'h00) begin
      init_reg <= LB_WDATA_I[5];
      filt_reg <= LB_WDATA_I[19];
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence bus_req; LB_RD_I || LB_WR_I; endsequence
  sequence cal_req; LB_WR_I && LB_ADDR_I == 7'h00 && LB_WDATA_I[7]; endsequence
  sequence zero_ref; INPUT_SEL_O == 2'h1; endsequence
  a_ack_after_req: assert property (bus_req |=> LB_ACK_O)
    else $error("missing bus acknowledge");
  a_no_stray_ack: assert property (!(LB_RD_I || LB_WR_I) |=> !LB_ACK_O)
    else $error("acknowledge without request");
  a_rdata_hold: assert property (!$past(LB_RD_I) |-> $stable(LB_RDATA_O))
    else $error("read data changed without a read");
  a_filter_follow: assert property (FILTER_LOW_O == $past(filt_reg))
    else $error("filter select differs from control bit");
  a_target_pass: assert property (!init_reg && !$past(init_reg)
    |-> EXT_CLK_O == $past(EXT_CLK_I)) else $error("target clock not passed");
  a_cal_zero_first: assert property (cal_req |-> ##[1:4] zero_ref)
    else $error("calibration did not route zero reference");
  a_sel_legal: assert property (INPUT_SEL_O != 2'h3)
    else $error("illegal input routing code");
  a_dma_idle: assert property ($fell(RESET_I) |-> !DMA_REQ_O)
    else $error("transfer request with empty buffer");
endmodule
bind acq_controller acq_monitor mon (.*);

// ### testbench/converter_model.sv
`timescale 1ns/1ps
module converter_model (
  input  wire logic              clk_i,
  input  wire logic              go_i,
  input  wire logic [1:0]        gap_i,
  input  wire logic [11:0][23:0] word_i,
  output logic                   frame_o,
  output logic                   bit_o,
  output logic                   sdata_o,
  output logic                   busy_o
);
  integer ch, b;
  initial begin
    frame_o = 1'b0;
    bit_o = 1'b0;
    sdata_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        frame_o <= 1'b1;
        @(posedge clk_i);
        frame_o <= 1'b0;
        for (ch = 0; ch < 12; ch++) begin
          for (b = 23; b >= 0; b--) begin
            bit_o <= 1'b1;
            sdata_o <= word_i[ch][b];
            @(posedge clk_i);
            if (gap_i != 2'h0) begin
              bit_o <= 1'b0;
              sdata_o <= ~word_i[ch][b];
              repeat (gap_i) @(posedge clk_i);
            end
          end
        end
        bit_o <= 1'b0;
        sdata_o <= ~sdata_o;
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// ### testbench/test_adc_acquisition_controller.sv
`timescale 1ns/1ps
module test_adc_acquisition_controller;
  logic              CLK_I = 1'b0;
  logic              RESET_I = 1'b1;
  logic              LOW_POWER_I = 1'b0;
  logic              LB_WR_I = 1'b0;
  logic              LB_RD_I = 1'b0;
  logic              EXT_CLK_I = 1'b0;
  logic              go = 1'b0;
  logic [6:0]        LB_ADDR_I = 7'h00;
  logic [31:0]       LB_WDATA_I = 32'h0;
  logic [31:0]       rdat;
  logic [1:0]        gap = 2'h0;
  logic [11:0][23:0] words = '0;
  wire  [31:0]       LB_RDATA_O;
  wire  [1:0]        ADC_SAMPLE_CLK_O, INPUT_SEL_O, RANGE_SEL_O;
  wire               LB_ACK_O, DMA_REQ_O, ADC_FRAME_I, ADC_BIT_I, ADC_SDATA_I;
  wire               ADC_SYNC_O, EXT_CLK_O, FILTER_LOW_O, busy;
  logic [31:0]       exp_q[$];
  logic [31:0]       msk_q[$];
  logic [6:0]        ofs[9];
  logic [31:0]       rst[9];
  integer            errors = 0;
  integer            check_count = 0;
  integer            cyc = 0;
  integer            i, n;
  longint            off[12], gn[12], d;

  acq_controller dut (.*);
  converter_model cm (.clk_i(CLK_I), .go_i(go), .gap_i(gap), .word_i(words),
    .frame_o(ADC_FRAME_I), .bit_o(ADC_BIT_I), .sdata_o(ADC_SDATA_I),
    .busy_o(busy));

  always #2 CLK_I = ~CLK_I;
  always @(posedge CLK_I) EXT_CLK_I <= 1'($urandom);

  task check(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task report_and_stop;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop;
    end
  end

  // Read results are compared in order of issue
  always @(posedge CLK_I) begin
    if (LB_ACK_O) begin
      if (msk_q[0] != 32'h0) check(LB_RDATA_O & msk_q[0], exp_q[0]);
      void'(msk_q.pop_front());
      void'(exp_q.pop_front());
    end
  end

  // One strobe cycle, acknowledge one cycle later
  task bus(input logic wr, input logic [6:0] a, input logic [31:0] dv,
           input logic [31:0] m);
    exp_q.push_back(dv);
    msk_q.push_back(wr ? 32'h0 : m);
    LB_ADDR_I <= a;
    LB_WDATA_I <= dv;
    LB_WR_I <= wr;
    LB_RD_I <= !wr;
    @(posedge CLK_I);
    LB_WR_I <= 1'b0;
    LB_RD_I <= 1'b0;
    @(posedge CLK_I);
    rdat = LB_RDATA_O;
  endtask

  task scan;
    gap <= 2'($urandom);
    go <= 1'b1;
    @(posedge CLK_I);
    go <= 1'b0;
    @(posedge CLK_I);
    for (n = 0; busy && n < 4000; n++) @(posedge CLK_I);
    repeat (4) @(posedge CLK_I);
  endtask

  task wait_bcr(input integer b, input logic val);
    n = 0;
    do begin
      bus(1'b0, 7'h00, 32'h0, 32'h0);
      n++;
    end while (rdat[b] !== val && n < 1000);
  endtask

  task wait_sel(input logic [1:0] s);
    for (n = 0; INPUT_SEL_O !== s && n < 100; n++) @(posedge CLK_I);
  endtask

  task gap_of_clock(output integer c);
    logic s;
    s = ADC_SAMPLE_CLK_O[0];
    for (c = 0; ADC_SAMPLE_CLK_O[0] === s && c < 600; c++) @(posedge CLK_I);
  endtask

  task calibrate(input logic bad);
    bus(1'b1, 7'h00, 32'h38BC, 32'h0);
    for (i = 0; i < 12; i++) begin
      off[i] = 1 + $urandom % 2000;
      words[i] = 24'(off[i]);
    end
    wait_sel(2'h1);
    scan;
    for (i = 0; i < 12; i++) begin
      d = (bad && i == 5) ? 0 : 64'h7EB851 - 2048 + $urandom % 4096;
      words[i] = 24'(off[i] + d);
      gn[i] = (d == 0) ? 64'h4000 : (64'h7EB851 << 14) / d;
    end
    wait_sel(2'h2);
    scan;
    wait_bcr(7, 1'b0);
    check({31'h0, rdat[7]}, 32'h0);
    check({31'h0, rdat[12]}, {31'h0, !bad});
  endtask

  function automatic logic [31:0] expw(input integer c, input logic [23:0] r);
    longint x;
    x = ((longint'($signed(r)) - off[c]) * gn[c]) >>> 14;
    if (x > 64'sh7FFFFF) x = 64'sh7FFFFF;
    if (x < -64'sh800000) x = -64'sh800000;
    return {3'h0, 5'(c), ~x[23], x[22:0]};
  endfunction

  initial begin
    ofs = '{7'h00, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h1C, 7'h20, 7'h14, 7'h40};
    rst = '{32'h383C, 32'h400032, 32'h400032, 32'h0, 32'h505, 32'h2000,
            32'h3FFFE, 32'h0, 32'h0};
    void'($urandom(34589));
    repeat (4) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    for (i = 0; i < 9; i++) bus(1'b0, ofs[i], rst[i], '1);
    gap_of_clock(n);
    gap_of_clock(n);
    check(32'(n), 32'd250);
    bus(1'b1, 7'h14, '1, 32'h0);
    bus(1'b0, 7'h14, 32'h0, '1);
    bus(1'b1, 7'h00, 32'h0008383C, 32'h0);
    bus(1'b0, 7'h00, 32'h0008383C, '1);
    bus(1'b1, 7'h00, 32'h383C, 32'h0);
    // Fill the buffer past its depth
    for (i = 0; i < 12; i++) words[i] = 24'($urandom);
    repeat (22) scan;
    bus(1'b0, 7'h00, 32'h783C, '1);
    bus(1'b0, 7'h20, 32'h0103FFFE, '1);
    bus(1'b0, 7'h28, 32'h100, '1);
    bus(1'b1, 7'h20, 32'h000BFFFE, 32'h0);
    bus(1'b0, 7'h28, 32'h0, '1);
    calibrate(1'b0);
    calibrate(1'b1);
    // Second group inactive, then corrected words only from the first
    bus(1'b1, 7'h0C, 32'h20, 32'h0);
    bus(1'b0, 7'h00, 32'h0, 32'h2000);
    wait_bcr(13, 1'b1);
    check({31'h0, rdat[13]}, 32'h1);
    for (i = 0; i < 12; i++) words[i] = 24'($urandom);
    scan;
    bus(1'b0, 7'h28, 32'h6, '1);
    check({31'h0, DMA_REQ_O}, 32'h1);
    for (i = 0; i < 6; i++) bus(1'b0, 7'h30, expw(i, words[i]), '1);
    bus(1'b0, 7'h30, 32'h0, '1);
    check({31'h0, DMA_REQ_O}, 32'h0);
    bus(1'b1, 7'h00, 32'h381C, 32'h0);
    repeat (20) @(posedge CLK_I);
    bus(1'b1, 7'h00, 32'h383C, 32'h0);
    RESET_I <= 1'b1;
    LOW_POWER_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    bus(1'b0, 7'h00, 32'h3838, '1);
    report_and_stop;
  end
endmodule
